// >>> ebm_map.svh
// How it works
// R01 - The bus reference clock either runs free or gives one low-high pulse per visible access, high part stretched for slow ones.
// R02 - Clock behaviour is chosen by the clock-disable bit, the internal visibility bit and the stretch select bit.
// R03 - The low byte strobe goes low only while the low data byte carries valid data, and stays high otherwise.
// R04 - In special peripheral mode the tester drives the transfer size pin low for 16-bit and high for 8-bit, and it is decoded so.
// R05 - In wide or emulation narrow modes with tagging and the low strobe on, a low on the tag pin at the falling clock edge tags the low half.
// R06 - Read/write is an output in the expanded modes, not in single-chip mode, and in special peripheral mode it is an input from the tester.
// R07 - The maskable interrupt pin is input only and stays readable as a port bit while its interrupt is on.
// R08 - The maskable interrupt request can be level or edge triggered.
// R09 - One port K pin can be an external data chip select and another an emulation chip select.
// R10 - The register block is relocatable, so only the low offsets are decoded.
// R11 - Unused locations read zero and ignore writes; unused bits read zero only in the interrupt status and mask registers.
// R12 - A direction bit of 1 makes its pin an output and 0 an input; reads give the pin for inputs and the latch for outputs.
// R13 - Pins whose bus function is not selected fall back to general-purpose I/O under their direction bits, except port E bits 0 and 1, which stay inputs.
`ifndef EBM_MAP_SVH
`define EBM_MAP_SVH

// ****************************************
// Register indexes (byte address = 4 x index)
// ****************************************
`define EBM_IDX_PA      8'h00
`define EBM_IDX_PB      8'h01
`define EBM_IDX_PA_DIR  8'h02
`define EBM_IDX_PB_DIR  8'h03
`define EBM_IDX_PE      8'h08
`define EBM_IDX_PE_DIR  8'h09
`define EBM_IDX_ASSIGN  8'h0A
`define EBM_IDX_MODE    8'h0B
`define EBM_IDX_PULL    8'h0C
`define EBM_IDX_DRIVE   8'h0D
`define EBM_IDX_BUSCTL  8'h0E
`define EBM_IDX_INTERRUPT_REQUEST_CONTROL   8'h1E
`define EBM_IDX_PK      8'h32
`define EBM_IDX_PK_DIR  8'h33
`define EBM_IDX_KFUNC   8'h34
`define EBM_IDX_ISTAT   8'h40
`define EBM_IDX_IMASK   8'h41

// ****************************************
// Field positions
// ****************************************
`define EBM_ASSIGN_CLKDIS 4
`define EBM_ASSIGN_STRBEN 3
`define EBM_ASSIGN_RWEN   2
`define EBM_MODE_VIS      3
`define EBM_MODE_MSB      7
`define EBM_MODE_LSB      5
`define EBM_CTL_STRETCH   0
`define EBM_CTL_TAGEN     1
`define EBM_IRQ_EDGE      7
`define EBM_IRQ_EN        6
`define EBM_KF_ECS        7
`define EBM_KF_XCS        6
`define EBM_KF_XA         5
`define EBM_INT_IRQ       0
`define EBM_INT_NMI       1
`define EBM_INT_DONE      2

// ****************************************
// Mode codes and reset values
// ****************************************
`define EBM_MD_SINGLE     3'h0
`define EBM_MD_NARROW     3'h1
`define EBM_MD_WIDE       3'h2
`define EBM_MD_EMU_NARROW 3'h3
`define EBM_MD_EMU_WIDE   3'h4
`define EBM_MD_PERIPH     3'h5
`define EBM_RST_BYTE      8'h00
`define EBM_RST_INT       3'h0

`endif

// >>> ebm_pkg.sv
package ebm_pkg;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'h1,
      ST_LOW     = 4'h2,
      ST_HIGH    = 4'h4,
      ST_STRETCH = 4'h8
   } ebm_state_type;

endpackage

// >>> ebm_top.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ebm_map.svh"

module ebm_top (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // AXI4-Lite slave
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Internal bus master access
   input  wire logic        acc_start,
   input  wire logic        acc_write,
   input  wire logic        acc_word,
   input  wire logic        acc_slow,
   input  wire logic        acc_internal,
   input  wire logic        acc_data_space,
   input  wire logic [19:0] acc_addr,
   input  wire logic [15:0] acc_wdata,
   output logic             acc_ready,
   output logic             acc_done,
   output logic [15:0]      acc_rdata,
   output logic             tag_low,
   // Port pins
   input  wire logic [7:0]  pa_in,
   output logic [7:0]       pa_out,
   output logic [7:0]       pa_oe,
   input  wire logic [7:0]  pb_in,
   output logic [7:0]       pb_out,
   output logic [7:0]       pb_oe,
   input  wire logic [7:0]  pe_in,
   output logic [7:0]       pe_out,
   output logic [7:0]       pe_oe,
   input  wire logic [7:0]  pk_in,
   output logic [7:0]       pk_out,
   output logic [7:0]       pk_oe,
   // Tester and pad control
   output logic             tester_write,
   output logic             tester_byte,
   output logic [7:0]       pull_en,
   output logic [7:0]       drive_reduced,
   // Interrupt
   output logic             irq
);

   // ****************************************
   // Declarations
   // ****************************************
   ebm_pkg::ebm_state_type st_r;
   logic [7:0]  pa_data_r, pb_data_r, pa_dir_r, pb_dir_r;
   logic [7:0]  pe_data_r, pe_dir_r, assign_r, mode_r;
   logic [7:0]  pull_r, drive_r, busctl_r, interrupt_request_control_r;
   logic [7:0]  pk_data_r, pk_dir_r, kfunc_r;
   logic [2:0]  istat_r, imask_r, iset, iclr;
   logic [31:0] aw_addr_r;
   logic [7:0]  w_byte_r;
   logic        w_lane_r, aw_have_r, w_have_r, bvalid_r;
   logic        awready_r, wready_r, arready_r, rvalid_r;
   logic        aw_have_nxt, w_have_nxt, bvalid_nxt, rvalid_nxt;
   logic        wr_fire, ar_fire, wr_en;
   logic [7:0]  wr_idx, rd_val;
   logic [31:0] rdata_r;
   logic        bus_reference_clock_r, vis_r, write_r, word_r, slow_r, dspace_r;
   logic [19:0] addr_r;
   logic [15:0] wdata_r, rdata_acc_r;
   logic        done_r, tag_r, twrite_r, tbyte_r, irq_r, cap_r;
   logic        irq_prev_r, nmi_prev_r, irq_evt, nmi_evt;
   logic [2:0]  md;
   logic        expd, wide, emu, periph, free_run, bus_on, lo_ph, hi_ph;
   logic        tag_on, low_byte_strobe_n_n;
   logic [7:0]  pa_o, pa_e, pb_o, pb_e, pe_o, pe_e, pk_o, pk_e;
   logic [7:0]  pa_out_r, pa_oe_r, pb_out_r, pb_oe_r;
   logic [7:0]  pe_out_r, pe_oe_r, pk_out_r, pk_oe_r;

   // Pin latch for outputs, pin level for inputs
   function automatic logic [7:0] pin_read(input logic [7:0] data, input logic [7:0] dir,
                                           input logic [7:0] pin);
      pin_read = (dir & data) | (~dir & pin);
   endfunction

   // ****************************************
   // Mode decode
   // ****************************************
   assign md       = mode_r[`EBM_MODE_MSB:`EBM_MODE_LSB];
   assign wide     = (md == `EBM_MD_WIDE) || (md == `EBM_MD_EMU_WIDE);
   assign emu      = (md == `EBM_MD_EMU_NARROW) || (md == `EBM_MD_EMU_WIDE);
   assign expd     = wide || emu || (md == `EBM_MD_NARROW);
   assign periph   = (md == `EBM_MD_PERIPH);
   assign free_run = !expd && !periph;
   assign bus_on   = !st_r[0] && vis_r;
   assign lo_ph    = (st_r == ebm_pkg::ST_LOW);
   assign hi_ph    = (st_r == ebm_pkg::ST_HIGH) || (st_r == ebm_pkg::ST_STRETCH);
   assign tag_on   = busctl_r[`EBM_CTL_TAGEN] && assign_r[`EBM_ASSIGN_STRBEN]
                     && ((md == `EBM_MD_WIDE) || (md == `EBM_MD_EMU_NARROW));
   assign low_byte_strobe_n_n  = !(bus_on && (word_r || addr_r[0]));                 // [R03]

   // ****************************************
   // AXI4-Lite handshakes
   // ****************************************
   // One write and one read at a time keeps the slave free of queues
   assign wr_fire     = aw_have_r && w_have_r && !bvalid_r;
   assign ar_fire     = s_axi_arvalid && arready_r;
   assign aw_have_nxt = (aw_have_r && !wr_fire) || (s_axi_awvalid && awready_r);
   assign w_have_nxt  = (w_have_r && !wr_fire) || (s_axi_wvalid && wready_r);
   assign bvalid_nxt  = wr_fire || (bvalid_r && !s_axi_bready);
   assign rvalid_nxt  = ar_fire || (rvalid_r && !s_axi_rready);
   assign wr_idx      = aw_addr_r[9:2];                                   // [R10]
   assign wr_en       = wr_fire && w_lane_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         {aw_have_r, w_have_r, bvalid_r, rvalid_r, awready_r, wready_r, arready_r, w_lane_r} <= 8'h00;
         aw_addr_r <= 32'h00000000;
         w_byte_r  <= 8'h00;
         rdata_r   <= 32'h00000000;
      end else begin
         aw_have_r <= aw_have_nxt;
         w_have_r  <= w_have_nxt;
         bvalid_r  <= bvalid_nxt;
         rvalid_r  <= rvalid_nxt;
         awready_r <= !aw_have_nxt && !bvalid_nxt;
         wready_r  <= !w_have_nxt && !bvalid_nxt;
         arready_r <= !rvalid_nxt;
         if (s_axi_awvalid && awready_r) begin
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_r) begin
            w_byte_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
         end
         if (ar_fire) begin
            rdata_r <= {24'h000000, rd_val};                              // [R11]
         end
      end
   end

   // ****************************************
   // Register read decode
   // ****************************************
   always_comb begin
      rd_val = 8'h00;
      case (s_axi_araddr[9:2])                                            // [R10]
         `EBM_IDX_PA:     rd_val = pin_read(pa_data_r, pa_dir_r, pa_in);  // [R12]
         `EBM_IDX_PB:     rd_val = pin_read(pb_data_r, pb_dir_r, pb_in);  // [R12]
         `EBM_IDX_PA_DIR: rd_val = pa_dir_r;
         `EBM_IDX_PB_DIR: rd_val = pb_dir_r;
         `EBM_IDX_PE:     rd_val = pin_read(pe_data_r, pe_dir_r & 8'hFC, pe_in); // [R07]
         `EBM_IDX_PE_DIR: rd_val = pe_dir_r;
         `EBM_IDX_ASSIGN: rd_val = assign_r;
         `EBM_IDX_MODE:   rd_val = mode_r;
         `EBM_IDX_PULL:   rd_val = pull_r;
         `EBM_IDX_DRIVE:  rd_val = drive_r;
         `EBM_IDX_BUSCTL: rd_val = busctl_r;
         `EBM_IDX_INTERRUPT_REQUEST_CONTROL:  rd_val = interrupt_request_control_r;
         `EBM_IDX_PK:     rd_val = pin_read(pk_data_r, pk_dir_r, pk_in);  // [R12]
         `EBM_IDX_PK_DIR: rd_val = pk_dir_r;
         `EBM_IDX_KFUNC:  rd_val = kfunc_r;
         `EBM_IDX_ISTAT:  rd_val = {5'h00, istat_r};
         `EBM_IDX_IMASK:  rd_val = {5'h00, imask_r};
         default:         rd_val = 8'h00;                                 // [R11]
      endcase
   end

   // ****************************************
   // Register writes
   // ****************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         {pa_data_r, pb_data_r, pa_dir_r, pb_dir_r, pe_data_r, pe_dir_r, assign_r, mode_r,
          pull_r, drive_r, busctl_r, interrupt_request_control_r, pk_data_r, pk_dir_r, kfunc_r} <= {15{`EBM_RST_BYTE}};
         imask_r   <= `EBM_RST_INT;
      end else if (wr_en) begin
         case (wr_idx)
            `EBM_IDX_PA:     pa_data_r <= w_byte_r;
            `EBM_IDX_PB:     pb_data_r <= w_byte_r;
            `EBM_IDX_PA_DIR: pa_dir_r  <= w_byte_r;
            `EBM_IDX_PB_DIR: pb_dir_r  <= w_byte_r;
            `EBM_IDX_PE:     pe_data_r <= w_byte_r;
            `EBM_IDX_PE_DIR: pe_dir_r  <= w_byte_r;
            `EBM_IDX_ASSIGN: assign_r  <= w_byte_r;
            `EBM_IDX_MODE:   mode_r    <= w_byte_r;
            `EBM_IDX_PULL:   pull_r    <= w_byte_r;
            `EBM_IDX_DRIVE:  drive_r   <= w_byte_r;
            `EBM_IDX_BUSCTL: busctl_r  <= w_byte_r;
            `EBM_IDX_INTERRUPT_REQUEST_CONTROL:  interrupt_request_control_r   <= w_byte_r;
            `EBM_IDX_PK:     pk_data_r <= w_byte_r;
            `EBM_IDX_PK_DIR: pk_dir_r  <= w_byte_r;
            `EBM_IDX_KFUNC:  kfunc_r   <= w_byte_r;
            `EBM_IDX_IMASK:  imask_r   <= w_byte_r[2:0];
            default:         ;                                            // [R11]
         endcase
      end
   end

   // ****************************************
   // Interrupt status
   // ****************************************
   assign irq_evt = interrupt_request_control_r[`EBM_IRQ_EN] && (interrupt_request_control_r[`EBM_IRQ_EDGE] ?
                    (irq_prev_r && !pe_in[1]) : !pe_in[1]);               // [R08]
   assign nmi_evt = nmi_prev_r && !pe_in[0];
   assign iset    = {done_r, nmi_evt, irq_evt};
   assign iclr    = (wr_en && (wr_idx == `EBM_IDX_ISTAT)) ? w_byte_r[2:0] : 3'h0;

   always_ff @(posedge mclk) begin
      if (rst) begin
         istat_r    <= `EBM_RST_INT;
         irq_prev_r <= 1'b1;
         nmi_prev_r <= 1'b1;
         irq_r      <= 1'b0;
      end else begin
         // Set beats clear so no event is lost
         istat_r    <= (istat_r & ~iclr) | iset;
         irq_prev_r <= pe_in[1];
         nmi_prev_r <= pe_in[0];
         irq_r      <= |(istat_r & imask_r);
      end
   end

   // ****************************************
   // Access sequencer and bus clock
   // ****************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_r        <= ebm_pkg::ST_IDLE;
         {bus_reference_clock_r, vis_r, write_r, word_r, slow_r, dspace_r, done_r, tag_r, cap_r} <= 9'h000;
         addr_r      <= 20'h00000;
         wdata_r     <= 16'h0000;
         rdata_acc_r <= 16'h0000;
      end else begin
         done_r <= cap_r;
         cap_r  <= 1'b0;
         if (cap_r) begin
            // Pins lag the state by a flop, so read data stands one edge late
            rdata_acc_r <= wide ? {pa_in, pb_in} : {8'h00, pa_in};
            tag_r       <= tag_on && !pe_in[3];                           // [R05]
         end
         case (st_r)
            ebm_pkg::ST_IDLE: begin
               if (acc_start) begin
                  bus_reference_clock_r   <= 1'b0;
                  vis_r    <= !acc_internal || mode_r[`EBM_MODE_VIS];     // [R02]
                  write_r  <= acc_write;
                  word_r   <= acc_word;
                  slow_r   <= acc_slow;
                  dspace_r <= acc_data_space;
                  addr_r   <= acc_addr;
                  wdata_r  <= acc_wdata;
                  st_r     <= ebm_pkg::ST_LOW;
               end else begin
                  // Divider limits the free clock to half the system rate
                  bus_reference_clock_r <= free_run ? !bus_reference_clock_r : 1'b0;                    // [R01]
               end
            end
            ebm_pkg::ST_LOW: begin
               bus_reference_clock_r <= free_run || vis_r;                               // [R01] [R02]
               st_r   <= ebm_pkg::ST_HIGH;
            end
            ebm_pkg::ST_HIGH, ebm_pkg::ST_STRETCH: begin
               if (st_r == ebm_pkg::ST_HIGH && slow_r && busctl_r[`EBM_CTL_STRETCH]) begin
                  st_r <= ebm_pkg::ST_STRETCH;                            // [R01] [R02]
               end else begin
                  bus_reference_clock_r <= 1'b0;
                  cap_r  <= 1'b1;
                  st_r   <= ebm_pkg::ST_IDLE;
               end
            end
            default: st_r <= ebm_pkg::ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Pin multiplexing
   // ****************************************
   always_comb begin
      pa_o = pa_data_r;                                                   // [R12] [R13]
      pa_e = pa_dir_r;
      pb_o = pb_data_r;
      pb_e = pb_dir_r;
      pk_o = pk_data_r;
      pk_e = pk_dir_r;
      pe_o = pe_data_r;
      pe_e = pe_dir_r & 8'hFC;                                            // [R07]
      if (!assign_r[`EBM_ASSIGN_CLKDIS] && !periph) begin
         pe_o[4] = bus_reference_clock_r;                                                // [R02]
         pe_e[4] = 1'b1;
      end
      if (expd) begin
         pa_o = lo_ph ? addr_r[15:8] : ((wide || !addr_r[0]) ? wdata_r[15:8] : wdata_r[7:0]);
         pa_e = {8{bus_on && (lo_ph || write_r)}};
         pb_o = lo_ph ? addr_r[7:0] : wdata_r[7:0];
         pb_e = {8{bus_on && (lo_ph || (wide && write_r))}};
         if (assign_r[`EBM_ASSIGN_STRBEN]) begin
            pe_o[3] = low_byte_strobe_n_n;                                            // [R03]
            pe_e[3] = !(tag_on && hi_ph);                                 // [R05]
         end
         if (assign_r[`EBM_ASSIGN_RWEN]) begin
            pe_o[2] = !(bus_on && write_r);                               // [R06]
            pe_e[2] = 1'b1;
         end
         if (kfunc_r[`EBM_KF_XA]) begin
            pk_o[5:0] = addr_r[19:14];
            pk_e[5:0] = 6'h3F;
         end
         if (kfunc_r[`EBM_KF_XCS]) begin
            pk_o[6] = !(bus_on && dspace_r);                              // [R09]
            pk_e[6] = 1'b1;
         end
         if (kfunc_r[`EBM_KF_ECS] && emu) begin
            pk_o[7] = !bus_on;                                            // [R09]
            pk_e[7] = 1'b1;
         end
      end
      if (periph) begin
         // Tester owns address, data, size and direction
         pa_e    = 8'h00;
         pb_e    = 8'h00;
         pe_e[3] = 1'b0;                                                  // [R04]
         pe_e[2] = 1'b0;                                                  // [R06]
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         {pa_out_r, pa_oe_r, pb_out_r, pb_oe_r, pe_out_r, pe_oe_r, pk_out_r, pk_oe_r} <= 64'h0000000000000000;
         {twrite_r, tbyte_r} <= 2'h0;
      end else begin
         pa_out_r <= pa_o;
         pa_oe_r  <= pa_e;
         pb_out_r <= pb_o;
         pb_oe_r  <= pb_e;
         pe_out_r <= pe_o;
         pe_oe_r  <= pe_e;
         pk_out_r <= pk_o;
         pk_oe_r  <= pk_e;
         twrite_r <= periph && !pe_in[2];                                 // [R06]
         tbyte_r  <= periph && pe_in[3];                                  // [R04]
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bresp   = 2'b00;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = 2'b00;
   assign s_axi_rvalid  = rvalid_r;
   assign acc_ready     = st_r[0];
   assign acc_done      = done_r;
   assign acc_rdata     = rdata_acc_r;
   assign tag_low       = tag_r;
   assign pa_out        = pa_out_r;
   assign pa_oe         = pa_oe_r;
   assign pb_out        = pb_out_r;
   assign pb_oe         = pb_oe_r;
   assign pe_out        = pe_out_r;
   assign pe_oe         = pe_oe_r;
   assign pk_out        = pk_out_r;
   assign pk_oe         = pk_oe_r;
   assign tester_write  = twrite_r;
   assign tester_byte   = tbyte_r;
   assign pull_en       = pull_r;
   assign drive_reduced = drive_r;
   assign irq           = irq_r;

endmodule

`default_nettype wire

// >>> ebm_top_chk.sv
`timescale 1ns/100ps
`default_nettype none

module ebm_top_chk (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // Register bus
   input wire logic        s_axi_awready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Access and pins
   input wire logic        acc_start,
   input wire logic        acc_ready,
   input wire logic        acc_done,
   input wire logic [7:0]  pe_oe,
   input wire logic        tester_write,
   input wire logic        tester_byte,
   input wire logic        irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_read_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   a_write_wait: assert property (
      s_axi_bvalid |-> !s_axi_awready && s_axi_bresp == 2'h0) else $error("write answer wrong");
   a_resp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer dropped");
   a_rdata_upper: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == 2'h0) else $error("read upper bits set");
   a_access_time: assert property (
      acc_start && acc_ready |=> !acc_ready ##[3:4] acc_done ##1 !acc_done) else $error("access length wrong");
   a_rw_input: assert property (
      tester_write |-> !pe_oe[2]) else $error("direction pin driven by tester and device");
   a_size_input: assert property (
      tester_byte |-> !pe_oe[3]) else $error("size pin driven in peripheral mode");
   a_irq_input: assert property (
      pe_oe[1:0] == 2'h0) else $error("interrupt pins driven");
   c_access: cover property (acc_done);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_tester: cover property (tester_write);
   c_irq: cover property (irq);
endmodule

`default_nettype wire

// >>> ebm_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

module ebm_pin_model (
   // Clock
   input wire logic        mclk,
   // Device side
   input wire logic [7:0]  out,
   input wire logic [7:0]  oe,
   // Far side
   input wire logic [7:0]  ext,
   input wire logic [7:0]  ext_en,
   output logic [7:0]      pin
);
   // Undriven lines wander so a stale value never reads as good
   logic [7:0] spin_r = 8'hA5;
   always_ff @(posedge mclk) begin
      spin_r <= ~spin_r;
   end
   always_comb begin
      pin = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & spin_r);
   end
endmodule

`default_nettype wire

// >>> test_ebm_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ebm_map.svh"

module test_ebm_top;
   logic        mclk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, acc_start = 1'b0, acc_write = 1'b0, acc_word = 1'b1;
   logic        acc_slow = 1'b0, acc_internal = 1'b0, acc_data_space = 1'b1, b1, lo_seen, cs_seen, hi_seen;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, acc_ready, acc_done;
   logic        tag_low, tester_write, tester_byte, irq;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rv, base = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [19:0] acc_addr = 20'h0;
   logic [15:0] acc_wdata = 16'h0, acc_rdata;
   logic [7:0]  pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pe_in, pe_out, pe_oe, pk_in, pk_out, pk_oe;
   logic [7:0]  pull_en, drive_reduced, pe_ext = 8'hFF, ext_on = 8'hFF;
   logic [23:0] tbl [9] = '{24'h02A5A5, 24'h035A5A, 24'h0CA5A5, 24'h0D5A5A, 24'h33A5A5,
                            24'h04FF00, 24'h07FF00, 24'h0FFF00, 24'h20FF00};
   int          err_total = 0, tests_run = 0, n;

   ebm_top u_ebm_top (.*);
   ebm_pin_model u_ebm_pin_model_a (.mclk(mclk), .out(pa_out), .oe(pa_oe), .ext(8'h3C), .ext_en(ext_on), .pin(pa_in));
   ebm_pin_model u_ebm_pin_model_b (.mclk(mclk), .out(pb_out), .oe(pb_oe), .ext(8'hC3), .ext_en(ext_on), .pin(pb_in));
   ebm_pin_model u_ebm_pin_model_e (.mclk(mclk), .out(pe_out), .oe(pe_oe), .ext(pe_ext), .ext_en(ext_on), .pin(pe_in));
   ebm_pin_model u_ebm_pin_model_k (.mclk(mclk), .out(pk_out), .oe(pk_oe), .ext(8'h00), .ext_en(8'h0F), .pin(pk_in));

   initial begin
      forever #5 mclk = ~mclk;
   end

   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic guard(input int k);
      if (k >= 40) begin
         err_total++;
         summarize();
      end
   endtask
   task automatic wr(input logic [7:0] idx, d);
      s_axi_awaddr <= base | {22'h0, idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 40);
      s_axi_bready <= 1'b0;
      guard(n);
      @(posedge mclk);
   endtask
   task automatic rdc(input string nm, input logic [7:0] idx, e);
      s_axi_araddr <= base | {22'h0, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 40);
      rv = s_axi_rdata;
      s_axi_rready <= 1'b0;
      guard(n);
      @(posedge mclk);
      if (nm != "") chk(nm, {24'h0, e}, rv);
   endtask
   task automatic wirq(input logic e);
      n = 0;
      while (irq !== e && n < 40) begin
         @(posedge mclk);
         n++;
      end
      guard(n);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask
   task automatic acc(input logic w, sl);
      acc_start <= 1'b1;
      acc_write <= w;
      acc_slow <= sl;
      acc_word <= !sl;
      acc_addr <= {19'h0, sl};
      {lo_seen, cs_seen, hi_seen} = 3'b000;
      n = 0;
      @(posedge mclk);
      acc_start <= 1'b0;
      do begin
         @(posedge mclk);
         n++;
         lo_seen |= pe_oe[3] & !pe_out[3];
         cs_seen |= pk_oe[6] & !pk_out[6];
         hi_seen |= pe_oe[4] & pe_out[4];
      end while (!acc_done && n < 40);
      guard(n);
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      foreach (tbl[i]) begin
         rdc("reset", tbl[i][23:16], 8'h00);
         wr(tbl[i][23:16], tbl[i][15:8]);
         rdc("rw", tbl[i][23:16], tbl[i][7:0]);
         wr(tbl[i][23:16], 8'h00);
      end
      base = 32'h0000_F000;
      wr(`EBM_IDX_PA_DIR, 8'hF0);
      base = 32'h0;
      rdc("reloc", `EBM_IDX_PA_DIR, 8'hF0);
      wr(`EBM_IDX_PA, 8'h5A);
      rdc("port_a", `EBM_IDX_PA, 8'h5C);
      chk("pa_drive", 32'h50F0, {16'h0, pa_out & pa_oe, pa_oe});
      b1 = pe_out[4];
      @(posedge mclk);
      chk("free_clk", 32'h1, {31'h0, (pe_out[4] ^ b1) & pe_oe[4]});
      $display("test registers end");
      pe_ext <= 8'hFD;
      wr(`EBM_IDX_INTERRUPT_REQUEST_CONTROL, 8'h40);
      wr(`EBM_IDX_IMASK, 8'h01);
      wirq(1'b1);
      rdc("", `EBM_IDX_PE, 8'h00);
      chk("pe1_pin", 32'h0, rv & 32'h2);
      wr(`EBM_IDX_IMASK, 8'h00);
      wirq(1'b0);
      pe_ext <= 8'hFF;
      wr(`EBM_IDX_ISTAT, 8'h01);
      rdc("level_clr", `EBM_IDX_ISTAT, 8'h00);
      wr(`EBM_IDX_INTERRUPT_REQUEST_CONTROL, 8'hC0);
      pe_ext <= 8'hFD;
      wr(`EBM_IDX_IMASK, 8'h01);
      wirq(1'b1);
      wr(`EBM_IDX_ISTAT, 8'h01);
      rdc("edge_clr", `EBM_IDX_ISTAT, 8'h00);
      wr(`EBM_IDX_IMASK, 8'h00);
      pe_ext <= 8'hF3;
      $display("test interrupts end");
      wr(`EBM_IDX_MODE, 8'hA0);
      repeat (2) @(posedge mclk);
      chk("tester_rw", 32'h4, {29'h0, tester_write, tester_byte, pe_oe[2]});
      pe_ext <= 8'hFF;
      repeat (2) @(posedge mclk);
      chk("tester_sz", 32'h2, {29'h0, tester_write, tester_byte, pe_oe[3]});
      $display("test peripheral end");
      wr(`EBM_IDX_MODE, 8'h40);
      wr(`EBM_IDX_ASSIGN, 8'h0C);
      wr(`EBM_IDX_KFUNC, 8'h40);
      chk("rw_out", 32'h1, {31'h0, pe_oe[2]});
      acc(1'b0, 1'b0);
      chk("acc_len", 32'h4, n);
      chk("acc_rdata", 32'h3CC3, {16'h0, acc_rdata});
      chk("acc_pins", 32'h7, {29'h0, lo_seen, cs_seen, hi_seen});
      wr(`EBM_IDX_BUSCTL, 8'h03);
      pe_ext <= 8'hF7;
      acc(1'b1, 1'b1);
      chk("slow_len", 32'h5, n);
      chk("tag_low", 32'h1, {31'h0, tag_low});
      $display("test access end");
      summarize();
   end
endmodule

bind ebm_top ebm_top_chk u_ebm_top_chk (.*);

`default_nettype wire
